// ==== aic_input_config.sv ====
/*
 * Analog input configuration and conversion sequencing for a 10-bit
 * successive-approximation converter, reached over APB.
 * Assumes an analog comparator whose answer arrives on i_cmp_above in
 * the clock domain of i_clock, and analog switches driven by o_analog.
 */
// Added by the designer: the APB interface to the registers.
// Summary of operation
// - Conversions are ten-bit successive approximations, run singly or continuously.
// - While a conversion runs, writes to the input configuration register are ignored.
// - Bit 7 set connects the positive sensor supply pin to the internal 5 V supply.
// - Bit 6 set connects the negative sensor supply pin to analog ground.
// - Bits 5 and 4 enable temperature measurement on inputs four and three.
// - A temperature-enabled input ignores its absolute or ratiometric bit.
// - Bits 3 to 0 pick absolute (1) or ratiometric (0) for inputs four to one.
// - After reset the configuration register holds all zeros.
// - Ratiometric inputs take the reference from the sensor supply sense pins.
// - Signed ratiometric results are positive above mid-span and negative below.
// - Absolute inputs convert against the internal reference.
// - Temperature measurement drives the current source at two levels in ratio 1:10.
// - The single-conversion bit starts one conversion (a low- then high-current pair on a temperature input) and clears itself on completion.
// - The continuous bit converts repeatedly and wins when both bits are set.
`timescale 1ns/1ps
`include "aic_params.svh"

module aic_input_config (
    input  wire logic                       i_clock,       // System clock, 100 MHz
    input  wire logic                       i_rst,         // Async reset, active high
    input  wire aic_pkg::aic_apb_req_t      i_apb,         // APB request
    output logic [31:0]                     o_prdata,      // APB read data
    output logic                            o_pready,      // APB ready
    output logic                            o_pslverr,     // APB error
    input  wire logic [1:0]                 i_channel,     // Selected input, 0 = input one
    input  wire logic                       i_signed_mode, // Signed result format
    input  wire logic                       i_cmp_above,   // Comparator output, synchronous
    output aic_pkg::aic_analog_t            o_analog,      // Switch and reference controls
    output logic [`AIC_RES_W-1:0]           o_dac_trial,   // Trial code to the SAR DAC
    output logic [`AIC_RES_W-1:0]           o_result,      // Last completed result
    output logic                            o_busy         // Conversion in progress
);
    import aic_pkg::*;

    aic_config_t                 cfg_ff;
    logic                        single_go_ff;
    logic                        cont_go_ff;
    aic_state_t                  state_ff;
    aic_state_t                  nxt_state;
    logic [3:0]                  settle_ff;
    logic [3:0]                  bit_idx_ff;
    logic [`AIC_RES_W-1:0]       trial_ff;
    logic [`AIC_RES_W-1:0]       result_ff;
    logic                        temp_hi_ff;
    logic [`AIC_RES_W-1:0]       temp_lo_ff;
    logic                        busy;
    logic                        wr_access;
    logic                        temp_sel;
    logic                        abs_sel;
    logic                        done;
    logic [31:0]                 nxt_prdata;
    logic                        addr_ok;

    // Temperature mode applies only to inputs three and four
    function automatic logic chan_temp(input aic_config_t c, input logic [1:0] ch);
        chan_temp = (ch == 2'h2) ? c.input3_temp_meas_en :
                    (ch == 2'h3) ? c.input4_temp_meas_en : 1'b0;
    endfunction : chan_temp

    function automatic logic addr_hit(input logic [`AIC_ADDR_W-1:0] a);
        addr_hit = (a == `AIC_OFF_INPUT_CONFIG) || (a == `AIC_OFF_CONV_CTRL) ||
                   (a == `AIC_OFF_CONV_STATUS)  || (a == `AIC_OFF_RESULT);
    endfunction : addr_hit

    assign busy      = single_go_ff | cont_go_ff | (state_ff != AIC_IDLE);
    assign o_busy    = busy;
    assign wr_access = i_apb.psel & i_apb.penable & i_apb.pwrite;
    assign temp_sel  = chan_temp(cfg_ff, i_channel);
    assign abs_sel   = cfg_ff.input_absolute_sel[i_channel] & ~temp_sel;
    assign done      = (state_ff == AIC_DONE);
    assign addr_ok   = addr_hit(i_apb.paddr);
    assign o_pready  = 1'b1;
    assign o_pslverr = i_apb.psel & i_apb.penable & ~addr_ok;

    // Configuration register, locked while converting
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            cfg_ff <= `AIC_CFG_RESET;
        end else if (wr_access && i_apb.paddr == `AIC_OFF_INPUT_CONFIG && !busy) begin
            cfg_ff <= i_apb.pwdata[7:0];
        end
    end

    // Conversion control bits; completion clears the single bit
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            {cont_go_ff, single_go_ff} <= `AIC_CTRL_RESET;
        end else if (wr_access && i_apb.paddr == `AIC_OFF_CONV_CTRL) begin
            cont_go_ff   <= i_apb.pwdata[`AIC_BIT_CONT_GO];
            single_go_ff <= i_apb.pwdata[`AIC_BIT_SINGLE_GO];
        end else if (done && !(temp_sel && !temp_hi_ff)) begin
            // A temperature start keeps the bit through its low-current pass
            single_go_ff <= 1'b0;
        end
    end

    // Sequencer: settle, optional high-current phase, then ten trial bits
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            AIC_IDLE:   if (single_go_ff || cont_go_ff) nxt_state = AIC_SAMPLE;
            AIC_SAMPLE: if (settle_ff == `AIC_SETTLE_CYCLES)
                            nxt_state = (temp_sel && temp_hi_ff) ? AIC_CURHI : AIC_BITS;
            AIC_CURHI:  if (settle_ff == `AIC_SETTLE_CYCLES) nxt_state = AIC_BITS;
            AIC_BITS:   if (bit_idx_ff == 4'h0) nxt_state = AIC_DONE;
            AIC_DONE:   nxt_state = (cont_go_ff || (temp_sel && !temp_hi_ff))
                                    ? AIC_SAMPLE : AIC_IDLE;
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_ff <= AIC_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Settling counter restarts on every phase change
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            settle_ff <= 4'h0;
        end else if (nxt_state != state_ff) begin
            settle_ff <= 4'h0;
        end else if (settle_ff != `AIC_SETTLE_CYCLES) begin
            settle_ff <= settle_ff + 4'h1;
        end
    end

    // Binary search from the top bit down
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            trial_ff   <= '0;
            bit_idx_ff <= 4'h0;
        end else if (state_ff != AIC_BITS && nxt_state == AIC_BITS) begin
            trial_ff   <= {1'b1, {(`AIC_RES_W-1){1'b0}}};
            bit_idx_ff <= 4'(`AIC_RES_MSB);
        end else if (state_ff == AIC_BITS) begin
            if (!i_cmp_above) begin
                trial_ff[bit_idx_ff] <= 1'b0;
            end
            if (bit_idx_ff != 4'h0) begin
                trial_ff[bit_idx_ff - 4'h1] <= 1'b1;
                bit_idx_ff <= bit_idx_ff - 4'h1;
            end
        end
    end

    // Temperature: first conversion at low current, second at high
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            temp_hi_ff <= 1'b0;
            temp_lo_ff <= '0;
        end else if (done && temp_sel && !temp_hi_ff) begin
            temp_hi_ff <= 1'b1;
            temp_lo_ff <= trial_ff;
        end else if (done || state_ff == AIC_IDLE) begin
            temp_hi_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            result_ff <= '0;
        end else if (done) begin
            result_ff <= trial_ff;
        end
    end

    // Analog switch and reference controls, registered
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_analog <= '0;
        end else begin
            o_analog.pos_supply_internal <= cfg_ff.pos_supply_internal_en;
            o_analog.neg_supply_ground   <= cfg_ff.neg_supply_internal_en;
            o_analog.ref_from_sense      <= ~abs_sel;
            o_analog.signed_about_mid    <= i_signed_mode & ~abs_sel;
            o_analog.current_en3         <= cfg_ff.input3_temp_meas_en;
            o_analog.current_en4         <= cfg_ff.input4_temp_meas_en;
            o_analog.current_level       <= (temp_sel && (temp_hi_ff || state_ff == AIC_CURHI))
                                            ? `AIC_CUR_HIGH_LEVEL
                                            : `AIC_CUR_LOW_LEVEL;
        end
    end

    assign o_dac_trial = trial_ff;
    assign o_result    = result_ff;

    // Read mux
    always_comb begin
        nxt_prdata = 32'h0;
        unique case (i_apb.paddr)
            `AIC_OFF_INPUT_CONFIG: nxt_prdata[7:0] = cfg_ff;
            `AIC_OFF_CONV_CTRL: begin
                nxt_prdata[`AIC_BIT_CONT_GO]   = cont_go_ff;
                nxt_prdata[`AIC_BIT_SINGLE_GO] = single_go_ff;
            end
            `AIC_OFF_CONV_STATUS: nxt_prdata[`AIC_RES_W-1:0] = temp_lo_ff;
            `AIC_OFF_RESULT:      nxt_prdata[`AIC_RES_W-1:0] = result_ff;
            default:              nxt_prdata = {31'h0, busy};
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_prdata <= 32'h0;
        end else if (i_apb.psel && !i_apb.penable && !i_apb.pwrite) begin
            o_prdata <= addr_ok ? nxt_prdata : 32'h0;
        end
    end

endmodule : aic_input_config

// ==== aic_input_config_monitor.sv ====
/* Checker for the analog input configuration block.
   Assumes binding to aic_input_config; sees only its ports. */
`timescale 1ns/1ps
module aic_input_config_monitor (
    input wire logic                  i_clock,   // Clock
    input wire logic                  i_rst,     // Async reset
    input wire aic_pkg::aic_apb_req_t i_apb,     // APB request
    input wire logic                  o_pready,  // APB ready
    input wire logic                  o_pslverr, // APB error
    input wire aic_pkg::aic_analog_t  o_analog,  // Analog controls
    input wire logic                  o_busy     // Conversion running
);
    import aic_pkg::*;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    logic acc;
    logic mapped;
    assign acc = i_apb.psel && i_apb.penable;
    assign mapped = i_apb.paddr inside {8'h10, 8'h12, 8'h14, 8'h18};
    sequence cfg_wr;
        acc && i_apb.pwrite && i_apb.paddr == 8'h10;
    endsequence
    sequence conv_start;
        $rose(o_busy);
    endsequence
    ready_const_a: assert property (o_pready) else $error("ready low");
    unmapped_err_a: assert property (acc && !mapped |-> o_pslverr) else $error("no error");
    mapped_ok_a: assert property (acc && mapped |-> !o_pslverr) else $error("bad error");
    pos_supply_a: assert property (cfg_wr ##0 !o_busy |->
        ##2 o_analog.pos_supply_internal == $past(i_apb.pwdata[7], 2)) else $error("pos");
    neg_supply_a: assert property (cfg_wr ##0 !o_busy |->
        ##2 o_analog.neg_supply_ground == $past(i_apb.pwdata[6], 2)) else $error("neg");
    cfg_lock_a: assert property (cfg_wr ##0 o_busy |-> ##2
        ($stable(o_analog.pos_supply_internal) && $stable(o_analog.neg_supply_ground)))
        else $error("write landed while busy");
    conv_len_a: assert property (conv_start |-> o_busy [*8]) else $error("short");
    cur_ratio_a: assert property (o_analog.current_level != 4'h0 |->
        o_analog.current_level inside {4'h1, 4'ha}) else $error("current level");
endmodule : aic_input_config_monitor
bind aic_input_config aic_input_config_monitor aic_input_config_monitor_i (
    .i_clock(i_clock), .i_rst(i_rst), .i_apb(i_apb), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_analog(o_analog), .o_busy(o_busy));

// ==== aic_params.svh ====
/*
 * Constants for the analog input configuration block: register offsets,
 * field positions, reset values and converter timing counts.
 * Assumes inclusion by the package and the design module only.
 */
`ifndef AIC_PARAMS_SVH
`define AIC_PARAMS_SVH

`define AIC_ADDR_W            8
`define AIC_OFF_INPUT_CONFIG  8'h10
`define AIC_OFF_CONV_CTRL     8'h12
`define AIC_OFF_CONV_STATUS   8'h14
`define AIC_OFF_RESULT        8'h18
`define AIC_CFG_RESET         8'h00
`define AIC_CTRL_RESET        2'h0
`define AIC_BIT_POS_SUP       7
`define AIC_BIT_NEG_SUP       6
`define AIC_BIT_IN4_TEMP      5
`define AIC_BIT_IN3_TEMP      4
`define AIC_BIT_CONT_GO       6
`define AIC_BIT_SINGLE_GO     5
`define AIC_RES_W             10
`define AIC_RES_MSB           9
`define AIC_SETTLE_CYCLES     4'h3
`define AIC_CUR_LOW_LEVEL     4'h1
`define AIC_CUR_HIGH_LEVEL    4'ha

`endif

// ==== aic_pkg.sv ====
/*
 * Types shared by the analog input configuration block.
 * Assumes aic_params.svh is on the include path.
 */
`include "aic_params.svh"

package aic_pkg;

    typedef struct packed {
        logic       pos_supply_internal_en;
        logic       neg_supply_internal_en;
        logic       input4_temp_meas_en;
        logic       input3_temp_meas_en;
        logic [3:0] input_absolute_sel;
    } aic_config_t;

    typedef struct packed {
        logic       pos_supply_internal;
        logic       neg_supply_ground;
        logic       ref_from_sense;
        logic       signed_about_mid;
        logic [3:0] current_level;
        logic       current_en3;
        logic       current_en4;
    } aic_analog_t;

    typedef struct packed {
        logic [`AIC_ADDR_W-1:0] paddr;
        logic                   psel;
        logic                   penable;
        logic                   pwrite;
        logic [31:0]            pwdata;
    } aic_apb_req_t;

    typedef enum logic [4:0] {
        AIC_IDLE   = 5'b00001,
        AIC_SAMPLE = 5'b00010,
        AIC_CURHI  = 5'b00100,
        AIC_BITS   = 5'b01000,
        AIC_DONE   = 5'b10000
    } aic_state_t;

endpackage : aic_pkg

// ==== aic_sensor_model.sv ====
/* Sensor model: one analog level per input, seen by the comparator.
   Assumes levels are given as converter codes by the bench. */
`timescale 1ns/1ps
module aic_sensor_model (
    input  wire logic [3:0][9:0] i_level,    // Level on each input
    input  wire logic [1:0]      i_channel,  // Selected input
    input  wire logic [9:0]      i_trial,    // Trial code
    output logic                 o_cmp_above // Input above trial
);
    // Half an LSB above the code, so an equal trial counts as above
    assign o_cmp_above = (i_level[i_channel] >= i_trial);
endmodule : aic_sensor_model

// ==== tb.sv ====
/* Testbench: register traffic, configuration lock and conversions.
   Assumes the design, package, sensor model and checker compiled. */
`timescale 1ns/1ps
module tb;
    import aic_pkg::*;
    logic              i_clock, i_rst, sgn, cmp, pready, pslverr, busy, err, ab;
    aic_apb_req_t      req;
    logic [31:0]       prdata, rd;
    logic [1:0]        chan;
    aic_analog_t       analog;
    logic [9:0]        trial, result;
    logic [3:0][9:0]   level;
    int                bad_count, tests_run, cycles, cfg, lv, n;

    aic_input_config aic_input_config_i (.i_clock(i_clock), .i_rst(i_rst), .i_apb(req),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_channel(chan),
        .i_signed_mode(sgn), .i_cmp_above(cmp), .o_analog(analog),
        .o_dac_trial(trial), .o_result(result), .o_busy(busy));
    aic_sensor_model aic_sensor_model_i (.i_level(level), .i_channel(chan),
        .i_trial(trial), .o_cmp_above(cmp));

    initial begin
        i_clock = 0;
        forever #5 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            final_report();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge i_clock);
        req.penable <= 1'b1;
        do @(posedge i_clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb
    task automatic wait_idle();
        n = 0;
        while (busy !== 1'b0 && n < 500) begin
            @(posedge i_clock);
            n++;
        end
        check(busy, 0);
    endtask : wait_idle
    task automatic final_report();
        if (bad_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    initial begin
        i_rst = 1;
        req = '0;
        chan = 0;
        sgn = 0;
        level = '0;
        n = $urandom(54);
        repeat (6) @(posedge i_clock);
        i_rst <= 0;
        apb(0, 8'h10, 0);
        check(rd, 0);
        check({analog.pos_supply_internal, analog.neg_supply_ground}, 0);
        apb(1, 8'h21, 32'h5a);
        check(err, 1);
        check(rd, 0);
        for (int ch = 0; ch < 4; ch++) begin
            cfg = ($urandom & 8'hcf) | (ch == 2 ? 8'h10 : 8'h00);
            lv = $urandom % 1024;
            chan <= 2'(ch);
            sgn <= 1'($urandom);
            level[ch] <= lv[9:0];
            apb(1, 8'h10, cfg);
            apb(0, 8'h10, 0);
            check(rd, cfg);
            check({analog.pos_supply_internal, analog.neg_supply_ground}, cfg[7:6]);
            ab = cfg[ch] && !(ch == 2 && cfg[4]);
            check(analog.ref_from_sense, !ab);
            check(analog.signed_about_mid, sgn && !ab);
            apb(1, 8'h12, 32'h20);
            apb(1, 8'h10, ~cfg);
            apb(0, 8'h10, 0);
            check(rd, cfg);
            wait_idle();
            check(result, lv);
            if (ch == 2) begin
                apb(0, 8'h14, 0);
                check(rd, lv);
            end
            apb(0, 8'h12, 0);
            check(rd, 0);
        end
        apb(1, 8'h12, 32'h60);
        repeat (60) @(posedge i_clock);
        check(busy, 1);
        apb(1, 8'h12, 0);
        wait_idle();
        check(result, lv);
        final_report();
    end
endmodule : tb
